// File: logic/otic_top.sv
// 16-bit timer with input capture, trim registers and axi4-lite slave
`default_nettype none
// Summary of operation
// - 16-bit up counter, software read/write, resets to zero.
// - with system clock selected, counter steps every clock edge.
// - general registers are 16-bit, read/write, compare or capture.
// - rising edge on capture pin A copies counter into register A.
// - with buffering on, capture moves old register A into register C.
// - capture A sets its status flag; software clears it.
// - capture A interrupts only while its enable bit is set.
// - control register picks clock source, clearing, output levels.
// - io control picks compare/capture and pin functions for A and B.
// - trim register drives the oscillator frequency setting directly.
// - protect register gates trim writes; whole-byte writes only.
// - clock control picks port functions, clock switch, reports state.
// - protect writes count only with qualifier zero; qualifier reads one.
// - once lockdown is set, trim writes are refused until reset.
// - trim writes need lockdown clear and trim write enable set.
module otic_top (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [otic_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [otic_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic CAPTURE_PIN_A_IN,
  output logic CAPTURE_PIN_A_OUT,
  output logic CAPTURE_PIN_A_OE_B,
  input wire logic CAPTURE_PIN_B_IN,
  output logic CAPTURE_PIN_B_OUT,
  output logic CAPTURE_PIN_B_OE_B,
  input wire logic SYS_CLK_STATE,
  output logic CLK_SWITCH_REQ,
  output logic [1:0] PORT_FUNC_SEL,
  output logic [7:0] TRIM_VALUE,
  output logic IRQ
);
  import otic_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [5:0] ctrl;
    logic [1:0] ier;
    logic [1:0] flags;
    logic [7:0] io0;
    logic [15:0] count;
    logic [15:0] capture_compare_a;
    logic [15:0] capture_compare_b;
    logic [15:0] capture_buffer_c;
    logic [2:0] ckcs;
    logic protect_write_enable;
    logic lock;
    logic twe;
    logic [7:0] trim;
    logic [2:0] pa_s;
    logic [2:0] pb_s;
    logic [1:0] cs_s;
    logic [2:0] div;
    logic out_a;
    logic out_b;
  } otic_st_s;

  localparam otic_st_s ST_RST = '{count: COUNT_RST, capture_compare_a: GR_RST, capture_compare_b: GR_RST,
    capture_buffer_c: GR_RST, trim: TRIM_RST, io0: IO0_RST, ctrl: CTRL_RST, default: '0};

  otic_st_s r_ff;
  otic_st_s nxt_r;
  logic wr;
  logic ar_take;
  logic tick;
  logic cap_a;
  logic cap_b;
  logic cmp_a;
  logic cmp_b;
  logic cnt_wr;
  logic clr_cnt;
  logic [2:0] mask;
  logic [1:0] flag_clr;
  logic [31:0] rd_mux;
  logic [1:0] rd_resp;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    unique case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    nxt_r = r_ff;
    // pin synchronisers; edges use stages two and three only
    nxt_r.pa_s = {r_ff.pa_s[1:0], CAPTURE_PIN_A_IN};
    nxt_r.pb_s = {r_ff.pb_s[1:0], CAPTURE_PIN_B_IN};
    nxt_r.cs_s = {r_ff.cs_s[0], SYS_CLK_STATE};
    nxt_r.div = r_ff.div + 3'h1;
    // prescaler: select 0 ticks every clock, 1..3 every 2, 4, 8 clocks
    mask = 3'((4'h1 << r_ff.ctrl[CTRL_CLKSEL +: 2]) - 4'h1);
    tick = (r_ff.div & mask) == mask;
    cap_a = r_ff.io0[IO_CAP_A] && edge_hit(r_ff.io0[IO_EDGE_A +: 2],
      r_ff.pa_s[1] & ~r_ff.pa_s[2], ~r_ff.pa_s[1] & r_ff.pa_s[2]);
    cap_b = r_ff.io0[IO_CAP_B] && edge_hit(r_ff.io0[IO_EDGE_B +: 2],
      r_ff.pb_s[1] & ~r_ff.pb_s[2], ~r_ff.pb_s[1] & r_ff.pb_s[2]);
    cmp_a = !r_ff.io0[IO_CAP_A] && r_ff.mode[MODE_RUN] && tick && r_ff.count == r_ff.capture_compare_a;
    cmp_b = !r_ff.io0[IO_CAP_B] && r_ff.mode[MODE_RUN] && tick && r_ff.count == r_ff.capture_compare_b;
    clr_cnt = r_ff.ctrl[CTRL_CLR_A] && (cap_a || cmp_a);
    // register write once both address and data are held
    wr = r_ff.aw_held && r_ff.w_held && !r_ff.bvalid;
    cnt_wr = wr && r_ff.awaddr == OFS_COUNT && r_ff.wstrb[1:0] == 2'h3;
    flag_clr = 2'h0;
    if (r_ff.bvalid && BREADY)
    begin
      nxt_r.bvalid = 1'b0;
      nxt_r.aw_held = 1'b0;
      nxt_r.w_held = 1'b0;
    end
    if (AWVALID && !r_ff.aw_held)
    begin
      nxt_r.aw_held = 1'b1;
      nxt_r.awaddr = AWADDR;
    end
    if (WVALID && !r_ff.w_held)
    begin
      nxt_r.w_held = 1'b1;
      nxt_r.wdata = WDATA;
      nxt_r.wstrb = WSTRB;
    end
    if (wr)
    begin
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = RESP_OKAY;
      unique case (r_ff.awaddr)
        OFS_MODE: if (r_ff.wstrb[0]) nxt_r.mode = r_ff.wdata[1:0];
        OFS_CTRL:
          if (r_ff.wstrb[0])
          begin
            nxt_r.ctrl = r_ff.wdata[5:0];
            nxt_r.out_a = r_ff.wdata[CTRL_LVL_A];
            nxt_r.out_b = r_ff.wdata[CTRL_LVL_B];
          end
        OFS_IER: if (r_ff.wstrb[0]) nxt_r.ier = r_ff.wdata[1:0];
        OFS_STAT: if (r_ff.wstrb[0]) flag_clr = r_ff.wdata[1:0];
        OFS_IO0: if (r_ff.wstrb[0]) nxt_r.io0 = r_ff.wdata[7:0];
        OFS_COUNT: if (cnt_wr) nxt_r.count = r_ff.wdata[15:0];
        OFS_GRA: nxt_r.capture_compare_a = merge16(r_ff.capture_compare_a, r_ff.wdata, r_ff.wstrb);
        OFS_GRB: nxt_r.capture_compare_b = merge16(r_ff.capture_compare_b, r_ff.wdata, r_ff.wstrb);
        OFS_GRC: nxt_r.capture_buffer_c = merge16(r_ff.capture_buffer_c, r_ff.wdata, r_ff.wstrb);
        OFS_CKCS:
          if (r_ff.wstrb[0])
          begin
            nxt_r.ckcs = {r_ff.wdata[CKCS_PF +: 2], r_ff.wdata[CKCS_SW]};
          end
        OFS_PROT:
          if (r_ff.wstrb[0] && !r_ff.wdata[PROT_WRI])
          begin
            nxt_r.protect_write_enable = r_ff.wdata[PROT_PROTECT_WRITE_ENABLE];
            if (r_ff.protect_write_enable)
            begin
              nxt_r.lock = r_ff.lock | r_ff.wdata[PROT_LOCK];
              nxt_r.twe = r_ff.wdata[PROT_TWE];
            end
          end
        OFS_TRIM:
          if (r_ff.wstrb[0] && !r_ff.lock && r_ff.twe)
          begin
            nxt_r.trim = r_ff.wdata[7:0];
          end
        default: nxt_r.bresp = RESP_SLVERR;
      endcase
    end
    // counter: software write, then clear, then count; wraps naturally
    if (!cnt_wr)
    begin
      if (clr_cnt)
      begin
        nxt_r.count = COUNT_RST;
      end
      else if (r_ff.mode[MODE_RUN] && tick)
      begin
        nxt_r.count = r_ff.count + 16'h0001;
      end
    end
    // captures override a same-cycle software write
    if (cap_a)
    begin
      nxt_r.capture_compare_a = r_ff.count;
      if (r_ff.mode[MODE_BUFC])
      begin
        nxt_r.capture_buffer_c = r_ff.capture_compare_a;
      end
    end
    if (cap_b)
    begin
      nxt_r.capture_compare_b = r_ff.count;
    end
    if (cmp_a)
    begin
      nxt_r.out_a = !r_ff.out_a;
    end
    if (cmp_b)
    begin
      nxt_r.out_b = !r_ff.out_b;
    end
    // set wins over write-one-to-clear
    nxt_r.flags[FLAG_A] = (r_ff.flags[FLAG_A] & ~flag_clr[FLAG_A]) | cap_a | cmp_a;
    nxt_r.flags[FLAG_B] = (r_ff.flags[FLAG_B] & ~flag_clr[FLAG_B]) | cap_b | cmp_b;
    // read channel
    rd_mux = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    unique case (ARADDR)
      OFS_MODE: rd_mux[1:0] = r_ff.mode;
      OFS_CTRL: rd_mux[5:0] = r_ff.ctrl;
      OFS_IER: rd_mux[1:0] = r_ff.ier;
      OFS_STAT: rd_mux[1:0] = r_ff.flags;
      OFS_IO0: rd_mux[7:0] = r_ff.io0;
      OFS_COUNT: rd_mux[15:0] = r_ff.count;
      OFS_GRA: rd_mux[15:0] = r_ff.capture_compare_a;
      OFS_GRB: rd_mux[15:0] = r_ff.capture_compare_b;
      OFS_GRC: rd_mux[15:0] = r_ff.capture_buffer_c;
      OFS_CKCS:
        rd_mux[7:0] = {r_ff.ckcs[2:1], 4'h0, r_ff.cs_s[1], r_ff.ckcs[0]};
      OFS_PROT:
        rd_mux[7:0] = {1'b1, r_ff.protect_write_enable, r_ff.lock, r_ff.twe, 4'h0};
      OFS_TRIM: rd_mux[7:0] = r_ff.trim;
      default: rd_resp = RESP_SLVERR;
    endcase
    ar_take = ARVALID && !r_ff.rvalid;
    if (r_ff.rvalid && RREADY)
    begin
      nxt_r.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = rd_mux;
      nxt_r.rresp = rd_resp;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      r_ff <= ST_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign AWREADY = !r_ff.aw_held;
  assign WREADY = !r_ff.w_held;
  assign BVALID = r_ff.bvalid;
  assign BRESP = r_ff.bresp;
  assign ARREADY = !r_ff.rvalid;
  assign RVALID = r_ff.rvalid;
  assign RDATA = r_ff.rdata;
  assign RRESP = r_ff.rresp;
  // pins are driven only in compare mode
  assign CAPTURE_PIN_A_OUT = r_ff.out_a;
  assign CAPTURE_PIN_A_OE_B = r_ff.io0[IO_CAP_A];
  assign CAPTURE_PIN_B_OUT = r_ff.out_b;
  assign CAPTURE_PIN_B_OE_B = r_ff.io0[IO_CAP_B];
  assign CLK_SWITCH_REQ = r_ff.ckcs[0];
  assign PORT_FUNC_SEL = r_ff.ckcs[2:1];
  assign TRIM_VALUE = r_ff.trim;
  assign IRQ = |(r_ff.flags & r_ff.ier);

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  a_count_step: assert property (
    r_ff.mode[MODE_RUN] && tick && !cnt_wr && !clr_cnt
    |=> r_ff.count == 16'($past(r_ff.count) + 16'h0001))
    else $error("counter did not step");
  a_count_wrap: assert property (
    r_ff.mode[MODE_RUN] && tick && !cnt_wr && !clr_cnt && r_ff.count == 16'hFFFF
    |=> r_ff.count == 16'h0000)
    else $error("counter did not wrap to zero");
  a_capture_a_value: assert property (
    cap_a |=> r_ff.capture_compare_a == $past(r_ff.count))
    else $error("capture A did not take the count");
  a_buffer_c_move: assert property (
    cap_a && r_ff.mode[MODE_BUFC] |=> r_ff.capture_buffer_c == $past(r_ff.capture_compare_a))
    else $error("buffer C did not take old A");
  a_flag_a_set: assert property (
    cap_a |=> r_ff.flags[FLAG_A] && (!r_ff.ier[FLAG_A] || IRQ))
    else $error("capture A flag or interrupt missing");
  a_irq_masked: assert property (
    !r_ff.ier[FLAG_A] && !r_ff.ier[FLAG_B] |-> !IRQ)
    else $error("interrupt raised while masked");
  a_qualifier_reads: assert property (
    ar_take && ARADDR == OFS_PROT |=> RVALID && RDATA[PROT_WRI])
    else $error("qualifier bit read as zero");
  a_qualifier_block: assert property (
    wr && r_ff.awaddr == OFS_PROT && r_ff.wdata[PROT_WRI]
    |=> $stable(r_ff.protect_write_enable) && $stable(r_ff.twe) && $stable(r_ff.lock))
    else $error("protect changed with qualifier one");
  a_lock_holds: assert property (
    r_ff.lock |=> r_ff.lock && $stable(r_ff.trim))
    else $error("trim changed after lockdown");
  a_trim_gate: assert property (
    !r_ff.twe |=> $stable(r_ff.trim))
    else $error("trim written without enable");
  c_capture_buffered: cover property (cap_a && r_ff.mode[MODE_BUFC]);
  c_irq_rise: cover property (!IRQ ##1 IRQ);
  c_lockdown_set: cover property (!r_ff.lock ##1 r_ff.lock);
endmodule // otic_top
`default_nettype wire

// File: logic/otic_pkg.sv
// constants for the oscillator trim timer with input capture
`default_nettype none
package otic_pkg;
  localparam int ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_CTRL = 6'h04;
  localparam logic [5:0] OFS_IER = 6'h08;
  localparam logic [5:0] OFS_STAT = 6'h0C;
  localparam logic [5:0] OFS_IO0 = 6'h10;
  localparam logic [5:0] OFS_COUNT = 6'h14;
  localparam logic [5:0] OFS_GRA = 6'h18;
  localparam logic [5:0] OFS_GRB = 6'h1C;
  localparam logic [5:0] OFS_GRC = 6'h20;
  localparam logic [5:0] OFS_CKCS = 6'h24;
  localparam logic [5:0] OFS_PROT = 6'h28;
  localparam logic [5:0] OFS_TRIM = 6'h2C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // field positions
  localparam int MODE_RUN = 0;
  localparam int MODE_BUFC = 1;
  localparam int CTRL_CLKSEL = 0;
  localparam int CTRL_CLR_A = 2;
  localparam int CTRL_LVL_A = 4;
  localparam int CTRL_LVL_B = 5;
  localparam int IO_EDGE_A = 0;
  localparam int IO_CAP_A = 2;
  localparam int IO_EDGE_B = 4;
  localparam int IO_CAP_B = 6;
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int CKCS_SW = 0;
  localparam int CKCS_STATE = 1;
  localparam int CKCS_PF = 6;
  localparam int PROT_WRI = 7;
  localparam int PROT_PROTECT_WRITE_ENABLE = 6;
  localparam int PROT_LOCK = 5;
  localparam int PROT_TWE = 4;
  // capture edge encodings
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] IO0_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
endpackage
`default_nettype wire

// File: sim/otic_refclk_model.sv
// external reference clock source that drives capture pin a
`default_nettype none
module otic_refclk_model #(
  parameter int HALF_NS = 1000
) (
  input wire logic en,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // odd start offset keeps pin edges away from the bench clock edges
  initial
  begin
    pin = 1'b0;
    #13;
    forever
    begin
      #(HALF_NS);
      pin = en ? ~pin : 1'b0;
    end
  end
endmodule // otic_refclk_model
`default_nettype wire

// File: sim/oscillator_trim_input_capture_test.sv
// self-checking bench for the capture timer and trim registers
`default_nettype none
module oscillator_trim_input_capture_test;
  timeunit 1ns;
  timeprecision 1ps;
  import otic_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, ref_en = 1'b0, sys_state = 1'b0, pin_a;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq, clk_req, out_a, oe_a, out_b, oe_b;
  logic [1:0] bresp, rresp, pfs, wr_resp;
  logic [7:0] trim;
  int err_count = 0, tests_run = 0, cyc = 0, tk = 0;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  otic_refclk_model #(.HALF_NS(1000)) i_ref (.en(ref_en), .pin(pin_a));
  otic_top i_dut (
    .REF_CLK(clk), .RST_B(rst_b),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CAPTURE_PIN_A_IN(pin_a), .CAPTURE_PIN_A_OUT(out_a), .CAPTURE_PIN_A_OE_B(oe_a),
    .CAPTURE_PIN_B_IN(1'b0), .CAPTURE_PIN_B_OUT(out_b), .CAPTURE_PIN_B_OE_B(oe_b),
    .SYS_CLK_STATE(sys_state), .CLK_SWITCH_REQ(clk_req), .PORT_FUNC_SEL(pfs),
    .TRIM_VALUE(trim), .IRQ(irq)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    wr_resp = bresp;
    if (n >= 50)
      err_count++;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        tk = cyc;
      end
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50)
      err_count++;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rdc(OFS_COUNT, 32'h0000_0000);
    rdc(OFS_GRA, 32'h0000_FFFF);
    rdc(OFS_PROT, 32'h0000_0080);
    chk({24'h0, trim}, 32'h0000_0000);
    rd(6'h30, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(6'h30, 32'h0000_0000, 4'h1);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    wr(OFS_CTRL, 32'h0000_0030, 4'h1);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
    chk({28'h0, out_b, oe_b, out_a, oe_a}, 32'h0000_000A);
    sys_state <= 1'b1;
    wr(OFS_CKCS, 32'h0000_00C1, 4'h1);
    chk({29'h0, pfs, clk_req}, 32'h0000_0007);
    rdc(OFS_CKCS, 32'h0000_00C3);
    $display("test control done");
  endtask
  task automatic t_count;
    logic [31:0] v1, v2;
    logic [1:0] r;
    int t1;
    wr(OFS_COUNT, 32'h0000_1234, 4'h3);
    rdc(OFS_COUNT, 32'h0000_1234);
    wr(OFS_COUNT, 32'h0000_ABCD, 4'h1);
    rdc(OFS_COUNT, 32'h0000_1234);
    wr(OFS_GRB, 32'h0000_8001, 4'h3);
    rdc(OFS_GRB, 32'h0000_8001);
    wr(OFS_MODE, 32'h0000_0001, 4'h1);
    wr(OFS_COUNT, 32'h0000_FFF0, 4'h3);
    rd(OFS_COUNT, v1, r);
    t1 = tk;
    repeat (30) @(posedge clk);
    rd(OFS_COUNT, v2, r);
    chk(v2, {16'h0, v1[15:0] + 16'(tk - t1)});
    // divide by 8: a span of 40 edges always holds exactly 5 ticks
    wr(OFS_CTRL, 32'h0000_0003, 4'h1);
    rd(OFS_COUNT, v1, r);
    t1 = tk;
    repeat (38) @(posedge clk);
    rd(OFS_COUNT, v2, r);
    chk(v2, {16'h0, v1[15:0] + 16'((tk - t1) / 8)});
    wr(OFS_CTRL, 32'h0000_0000, 4'h1);
    $display("test counter done");
  endtask
  task automatic t_capture;
    logic [31:0] a, c;
    logic [1:0] r;
    int n;
    wr(OFS_IO0, 32'h0000_0004, 4'h1);
    chk({31'h0, oe_a}, 32'h0000_0001);
    wr(OFS_IER, 32'h0000_0001, 4'h1);
    wr(OFS_MODE, 32'h0000_0003, 4'h1);
    ref_en <= 1'b1;
    repeat (2)
    begin
      wr(OFS_STAT, 32'h0000_0001, 4'h1);
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (irq !== 1'b1 && n < 100);
      chk({31'h0, irq}, 32'h0000_0001);
    end
    rdc(OFS_STAT, 32'h0000_0001);
    rd(OFS_GRA, a, r);
    rd(OFS_GRC, c, r);
    // one reference period is 40 bench clocks
    chk({16'h0, a[15:0] - c[15:0]}, 32'h0000_0028);
    wr(OFS_STAT, 32'h0000_0001, 4'h1);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(OFS_IER, 32'h0000_0000, 4'h1);
    repeat (45) @(posedge clk);
    rdc(OFS_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    ref_en <= 1'b0;
    $display("test capture done");
  endtask
  task automatic t_trim;
    wr(OFS_TRIM, 32'h0000_005A, 4'h1);
    chk({24'h0, trim}, 32'h0000_0000);
    wr(OFS_PROT, 32'h0000_0040, 4'h1);
    wr(OFS_PROT, 32'h0000_0050, 4'h1);
    rdc(OFS_PROT, 32'h0000_00D0);
    wr(OFS_TRIM, 32'h0000_005A, 4'h1);
    chk({24'h0, trim}, 32'h0000_005A);
    wr(OFS_PROT, 32'h0000_00C0, 4'h1);
    rdc(OFS_PROT, 32'h0000_00D0);
    wr(OFS_PROT, 32'h0000_0060, 4'h1);
    wr(OFS_PROT, 32'h0000_0050, 4'h1);
    wr(OFS_TRIM, 32'h0000_0033, 4'h1);
    chk({24'h0, trim}, 32'h0000_005A);
    $display("test trim done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ctrl;
    t_count;
    t_capture;
    t_trim;
    results;
  end
  // the tests need well under 2000 clocks
  initial
  begin
    #1000000;
    err_count++;
    results;
  end
endmodule // oscillator_trim_input_capture_test
`default_nettype wire
